// File: hw/led_port_pkg.sv
package led_port_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_PORT0    = 5'h00;
  localparam logic [4:0] IDX_PORT9    = 5'h09;
  localparam logic [4:0] IDX_GRP_ALL  = 5'h0A;
  localparam logic [4:0] IDX_GRP_LO   = 5'h0B;
  localparam logic [4:0] IDX_GRP_MID  = 5'h0C;
  localparam logic [4:0] IDX_GRP_HI   = 5'h0D;
  localparam logic [4:0] IDX_IN_LOW   = 5'h0E;
  localparam logic [4:0] IDX_IN_HIGH  = 5'h0F;
  localparam logic [4:0] IDX_CONFIG   = 5'h10;

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam int CFG_RUN     = 0;
  localparam int CFG_CSRUN   = 1;
  localparam int CFG_RAMP    = 2;
  localparam int CFG_FADE    = 3;
  localparam int CFG_HOLD    = 4;
  localparam int CFG_STAGGER = 5;
  localparam int CFG_OSC     = 7;
  localparam logic [7:0] CFG_WR_MASK = 8'hA6;
  localparam logic [7:0] CFG_RST_INT = 8'h00;
  localparam logic [7:0] CFG_RST_EXT = 8'h80;

  // ----------------------------------------------------------------
  // Port level codes and reset value
  // ----------------------------------------------------------------
  localparam logic [7:0] LVL_LOW     = 8'h00;
  localparam logic [7:0] LVL_INPUT   = 8'h01;
  localparam logic [7:0] LVL_SINK    = 8'h02;
  localparam logic [7:0] LVL_PWM_MIN = 8'h03;
  localparam logic [7:0] LVL_HIZ     = 8'hFF;
  localparam logic [7:0] LVL_RST     = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 100000000;
  localparam int OSC_HZ       = 32000;
  localparam int OSC_TICK_CYC = CLK_HZ / OSC_HZ;
  localparam logic [7:0] PWM_LAST     = 8'hFF;
  localparam logic [7:0] STAGGER_STEP = 8'h20;
  localparam logic [2:0] SEQ_PERIODS  = 3'h4;

  typedef enum logic [2:0] {ST_SHUT, ST_HOLD, ST_FADE, ST_RAMP, ST_RUN} mode_t;

endpackage

// File: hw/port_drive.sv
`timescale 1ns/1ns
module port_drive
  import led_port_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] level,
  input  wire logic [7:0] phase,
  input  wire logic       drive_en,
  output logic            sink_r,
  output logic            pull_r
);

  logic sink_nxt;
  logic pull_nxt;

  // Decode level code into sink and open-drain pull-down
  always_comb
  begin
    pull_nxt = (level == LVL_LOW);
    sink_nxt = 1'b0;
    if (drive_en)
    begin
      if (level == LVL_SINK)
        sink_nxt = 1'b1;
      else if (level >= LVL_PWM_MIN && level != LVL_HIZ)
        sink_nxt = (phase < level);
    end
  end

  // Output flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sink_r <= 1'b0;
      pull_r <= 1'b0;
    end
    else
    begin
      sink_r <= sink_nxt;
      pull_r <= pull_nxt;
    end
  end

endmodule

// File: hw/led_port_top.sv
// What this block does
// - Run write during hold-off or fade-off aborts it and returns to run at once
// - Run clear read-back shows shutdown, fade-off or hold-off via status bits
// - Run set read-back shows ramp-up bit while ramping, zero in steady run
// - Stagger bit clear: all PWM ports in phase; set: phases offset
// - Bit seven clear: pin drives serial data, internal clock; set: pin is clock input
// - Port value one makes the port high impedance and a logic input
// - Input read returns pin level for input ports, zero for all others
// - Input registers are read-only; writes to them change nothing
// - Lower input register holds ports seven to zero, one per bit
// - Upper input register holds ports nine and eight in bits one and zero
// - Ten 8-bit port registers at consecutive addresses, one per port
// - Group addresses store one value into several port registers at once
// - Constant-current port sinks statically or PWM from 3 to 254 of 256
// - Variant parameter picks internal or external PWM clock at reset
// - Codes: 00 low, 01 input, 02 sink, 03-FE PWM, FF high impedance
// - PWM period is 256 PWM clock cycles
// - Stagger offsets ports in steps of 32 counts
// - Group 0A all, 0B ports 0-3, 0C 4-7, 0D 8-9; read gives lowest
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module led_port_top
  import led_port_pkg::*;
#(
  parameter bit EXT_CLK_DEFAULT = 1'b0
)
(
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [9:0]  PORT_I,
  output logic [9:0]       PORT_O,
  output logic [9:0]       PORT_OE,
  output logic [9:0]       PORT_SINK,
  input  wire logic        SER_DOUT,
  input  wire logic        DOUT_OSC_I,
  output logic             DOUT_OSC_O,
  output logic             DOUT_OSC_OE
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] reg_idx(input logic [7:0] a);
    reg_idx = a[6:2];
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'b00) && !a[7] && (reg_idx(a) <= IDX_CONFIG);
  endfunction

  function automatic logic [7:0] phase_off(input int n, input logic stag);
    phase_off = stag ? 8'((n % 8) * 32) : 8'h00;
  endfunction

  localparam logic [7:0] CFG_RST = EXT_CLK_DEFAULT ? CFG_RST_EXT : CFG_RST_INT;
  localparam logic [11:0] DIV_LAST = 12'(OSC_TICK_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  level_r [10];
  logic [7:0]  level_nxt [10];
  logic [7:0]  cfg_r, cfg_nxt;
  mode_t       mode_r, mode_nxt;
  logic [2:0]  seq_r, seq_nxt;
  logic [7:0]  pwm_r, pwm_nxt;
  logic [11:0] div_r, div_nxt;
  logic [2:0]  osc_sync_r, osc_sync_nxt;
  logic [9:0]  pin_s1_r, pin_s2_r;
  logic        pready_r, pready_nxt;
  logic        perr_r, perr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        dout_r, dout_nxt;
  logic        doe_r, doe_nxt;
  logic [9:0]  pin_o_r;
  logic [4:0]  idx;
  logic        wr_done, tick, period_end;
  logic        wr_cfg;
  logic [9:0]  in_vec;
  logic [7:0]  cfg_rd;
  logic [7:0]  phase [10];
  logic        drive_en;

  assign idx        = reg_idx(PADDR);
  assign wr_done    = PSEL && PENABLE && pready_r && PWRITE && addr_ok(PADDR);
  assign wr_cfg     = wr_done && (idx == IDX_CONFIG);
  assign tick       = cfg_r[CFG_OSC] ? (osc_sync_r[1] && !osc_sync_r[2]) : (div_r == DIV_LAST);
  assign period_end = tick && (pwm_r == PWM_LAST);
  assign drive_en   = (mode_r != ST_SHUT);

  // ----------------------------------------------------------------
  // Input pins and status views
  // ----------------------------------------------------------------
  // Mask pin levels to ports set as logic inputs
  always_comb
  begin
    for (int n = 0; n < 10; n++)
      in_vec[n] = (level_r[n] == LVL_INPUT) && pin_s2_r[n];
  end

  // Configuration read-back with live status
  always_comb
  begin
    cfg_rd = 8'h00;
    cfg_rd[CFG_OSC]     = cfg_r[CFG_OSC];
    cfg_rd[CFG_STAGGER] = cfg_r[CFG_STAGGER];
    cfg_rd[CFG_CSRUN]   = cfg_r[CFG_CSRUN];
    cfg_rd[CFG_HOLD]    = (mode_r == ST_HOLD);
    cfg_rd[CFG_FADE]    = (mode_r == ST_FADE);
    cfg_rd[CFG_RAMP]    = (mode_r == ST_RAMP);
    cfg_rd[CFG_RUN]     = (mode_r == ST_RUN) || (mode_r == ST_RAMP);
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, registered answer
  // ----------------------------------------------------------------
  always_comb
  begin
    pready_nxt = PSEL && PENABLE && !pready_r;
    perr_nxt   = pready_nxt && !addr_ok(PADDR);
    prdata_nxt = 32'h0000_0000;
    if (pready_nxt && !PWRITE && addr_ok(PADDR))
    begin
      if (idx <= IDX_PORT9)
        prdata_nxt[7:0] = level_r[idx[3:0]];
      else
        unique case (idx)
          IDX_GRP_ALL, IDX_GRP_LO: prdata_nxt[7:0] = level_r[0];
          IDX_GRP_MID:             prdata_nxt[7:0] = level_r[4];
          IDX_GRP_HI:              prdata_nxt[7:0] = level_r[8];
          IDX_IN_LOW:              prdata_nxt[7:0] = in_vec[7:0];
          IDX_IN_HIGH:             prdata_nxt[7:0] = {6'h00, in_vec[9:8]};
          default:                 prdata_nxt[7:0] = cfg_rd;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // Port level registers and group writes
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int n = 0; n < 10; n++)
    begin
      level_nxt[n] = level_r[n];
      if (wr_done)
      begin
        if (idx == 5'(n))
          level_nxt[n] = PWDATA[7:0];
        if (idx == IDX_GRP_ALL)
          level_nxt[n] = PWDATA[7:0];
        if (idx == IDX_GRP_LO && n < 4)
          level_nxt[n] = PWDATA[7:0];
        if (idx == IDX_GRP_MID && n >= 4 && n < 8)
          level_nxt[n] = PWDATA[7:0];
        if (idx == IDX_GRP_HI && n >= 8)
          level_nxt[n] = PWDATA[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and power mode sequence
  // ----------------------------------------------------------------
  always_comb
  begin
    cfg_nxt  = cfg_r;
    mode_nxt = mode_r;
    seq_nxt  = seq_r;
    if (wr_cfg)
      cfg_nxt = (PWDATA[7:0] & CFG_WR_MASK);
    if (mode_r inside {ST_HOLD, ST_FADE, ST_RAMP} && period_end)
      seq_nxt = seq_r + 3'h1;
    if (wr_cfg)
    begin
      seq_nxt = 3'h0;
      unique case (mode_r)
        ST_SHUT:
          if (PWDATA[CFG_RUN])
            mode_nxt = PWDATA[CFG_RAMP] ? ST_RAMP : ST_RUN;
        ST_HOLD, ST_FADE:
          if (PWDATA[CFG_RUN])
            mode_nxt = ST_RUN;
        ST_RAMP, ST_RUN:
          if (!PWDATA[CFG_RUN])
            mode_nxt = ST_HOLD;
      endcase
    end
    else if (period_end && seq_r == SEQ_PERIODS - 3'h1)
    begin
      seq_nxt = 3'h0;
      unique case (mode_r)
        ST_HOLD: mode_nxt = ST_FADE;
        ST_FADE: mode_nxt = ST_SHUT;
        ST_RAMP: mode_nxt = ST_RUN;
        default: mode_nxt = mode_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // PWM clock, counter and shared pin
  // ----------------------------------------------------------------
  always_comb
  begin
    osc_sync_nxt = {osc_sync_r[1:0], DOUT_OSC_I};
    div_nxt      = (div_r == DIV_LAST) ? 12'h000 : div_r + 12'h001;
    pwm_nxt      = tick ? pwm_r + 8'h01 : pwm_r;
    dout_nxt     = SER_DOUT;
    doe_nxt      = !cfg_r[CFG_OSC];
  end

  // Per-port phase with optional stagger
  always_comb
  begin
    for (int n = 0; n < 10; n++)
      phase[n] = pwm_r + phase_off(n, cfg_r[CFG_STAGGER]);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int n = 0; n < 10; n++)
        level_r[n] <= LVL_RST;
      cfg_r      <= CFG_RST;
      mode_r     <= ST_SHUT;
      seq_r      <= 3'h0;
      pwm_r      <= 8'h00;
      div_r      <= 12'h000;
      osc_sync_r <= 3'h0;
      pin_s1_r   <= 10'h000;
      pin_s2_r   <= 10'h000;
      pready_r   <= 1'b0;
      perr_r     <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      dout_r     <= 1'b0;
      doe_r      <= 1'b0;
      pin_o_r    <= 10'h000;
    end
    else
    begin
      level_r    <= level_nxt;
      cfg_r      <= cfg_nxt;
      mode_r     <= mode_nxt;
      seq_r      <= seq_nxt;
      pwm_r      <= pwm_nxt;
      div_r      <= div_nxt;
      osc_sync_r <= osc_sync_nxt;
      pin_s1_r   <= PORT_I;
      pin_s2_r   <= pin_s1_r;
      pready_r   <= pready_nxt;
      perr_r     <= perr_nxt;
      prdata_r   <= prdata_nxt;
      dout_r     <= dout_nxt;
      doe_r      <= doe_nxt;
      pin_o_r    <= 10'h000;
    end
  end

  // ----------------------------------------------------------------
  // Port drivers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 10; g++)
  begin : gen_port
    port_drive u_drv (
      .clk      (REF_CLK),
      .arst_n   (ARST_N),
      .level    (level_r[g]),
      .phase    (phase[g]),
      .drive_en (drive_en),
      .sink_r   (PORT_SINK[g]),
      .pull_r   (PORT_OE[g])
    );
  end

  assign PRDATA      = prdata_r;
  assign PREADY      = pready_r;
  assign PSLVERR     = perr_r;
  assign PORT_O      = pin_o_r;
  assign DOUT_OSC_O  = dout_r;
  assign DOUT_OSC_OE = doe_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  a_abort_to_run: assert property (
    wr_cfg && PWDATA[CFG_RUN] && mode_r inside {ST_HOLD, ST_FADE} |=> mode_r == ST_RUN)
    else $error("abort did not return to run");
  a_shut_status: assert property (
    pready_nxt && !PWRITE && idx == IDX_CONFIG && mode_r == ST_SHUT |=> PRDATA[4:2] == 3'b000 && !PRDATA[0])
    else $error("shutdown status wrong");
  a_ramp_status: assert property (
    mode_r == ST_RAMP |-> cfg_rd[CFG_RAMP] && cfg_rd[CFG_RUN] && !cfg_rd[CFG_FADE])
    else $error("ramp status wrong");
  a_input_mask: assert property (
    level_r[3] != LVL_INPUT |-> !in_vec[3])
    else $error("non-input port reads one");
  a_in_high_zero: assert property (
    PREADY && PSEL && !PWRITE && idx == IDX_IN_HIGH |-> PRDATA[7:2] == 6'h00)
    else $error("upper input bits not zero");
  a_ro_input: assert property (
    wr_done && idx == IDX_IN_LOW |=> $stable(level_r[0]) && $stable(cfg_r) && $stable(mode_r))
    else $error("input register write changed state");
  a_group_hi: assert property (
    wr_done && idx == IDX_GRP_HI |=> level_r[8] == $past(PWDATA[7:0]) && level_r[9] == $past(PWDATA[7:0]))
    else $error("group write missed ports");
  a_period_wrap: assert property (
    period_end |=> pwm_r == 8'h00)
    else $error("PWM period not 256");
  a_pin_dir: assert property (
    cfg_r[CFG_OSC] ##1 cfg_r[CFG_OSC] |-> !DOUT_OSC_OE)
    else $error("shared pin driven in clock mode");
  a_apb_wait: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("APB answer late");

  a_sink_shutdown: assert property (
    mode_r == ST_SHUT |=> PORT_SINK == 10'h000)
    else $error("sink on in shutdown");
  a_input_hiz: assert property (
    level_r[5] == LVL_INPUT |=> !PORT_OE[5] && !PORT_SINK[5])
    else $error("input port still drives");

  c_abort: cover property (mode_r == ST_FADE ##1 mode_r == ST_RUN);
  c_ramp: cover property (mode_r == ST_RAMP ##1 mode_r == ST_RUN);
  c_group_all: cover property (wr_done && idx == IDX_GRP_ALL);
  c_stagger_run: cover property (cfg_r[CFG_STAGGER] && mode_r == ST_RUN);

endmodule

// File: verif/pin_env.sv
`timescale 1ns/1ns
module pin_env
(
  input  wire logic [9:0] port_oe,
  input  wire logic [9:0] ext_level,
  input  wire logic       osc_run,
  input  wire logic       osc_o,
  input  wire logic       osc_oe,
  output logic      [9:0] port_i,
  output logic            osc_i
);
  logic osc_clk = 1'b0;

  // External PWM clock, 160 ns period, still while not enabled
  initial
  begin
    forever
    begin
      #80;
      osc_clk = osc_run ? ~osc_clk : 1'b0;
    end
  end

  // Pulled-up open-drain pins: low while the port pulls
  assign port_i = ~port_oe & ext_level;
  // Shared pin: device drives it, or the outside clock does
  assign osc_i = osc_oe ? osc_o : osc_clk;
endmodule

// File: verif/tb_led_port_top.sv
`timescale 1ns/1ns
module tb_led_port_top
  import led_port_pkg::*;
;
  typedef struct packed {logic [4:0] wi; logic [7:0] wd; logic [4:0] ri; logic [7:0] ex;} row_t;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ser_dout = 1'b0;
  logic        osc_run = 1'b0;
  logic [9:0]  ext_level = 10'h2A5;
  logic [31:0] prdata;
  logic        pready, pslverr, osc_o, osc_oe, osc_i;
  logic [9:0]  port_i, port_o, port_oe, port_sink;
  logic [7:0]  rd;
  logic        err;
  int          errors = 0;
  int          compares = 0;
  int          hi, d01, d08;
  row_t        rows [10] = '{
    '{5'h00, 8'h11, 5'h00, 8'h11}, '{5'h09, 8'h99, 5'h09, 8'h99},
    '{5'h0A, 8'h02, 5'h05, 8'h02}, '{5'h0B, 8'h33, 5'h03, 8'h33},
    '{5'h0C, 8'h44, 5'h04, 8'h44}, '{5'h0D, 8'h55, 5'h0D, 8'h55},
    '{5'h0D, 8'h55, 5'h07, 8'h44}, '{5'h0E, 8'hFF, 5'h0E, 8'h00},
    '{5'h10, 8'h60, 5'h10, 8'h20}, '{5'h0A, 8'h01, 5'h0B, 8'h01}};

  led_port_top #(.EXT_CLK_DEFAULT(1'b0)) led_port_top_i (
    .REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PORT_I(port_i), .PORT_O(port_o), .PORT_OE(port_oe), .PORT_SINK(port_sink),
    .SER_DOUT(ser_dout), .DOUT_OSC_I(osc_i), .DOUT_OSC_O(osc_o), .DOUT_OSC_OE(osc_oe));

  pin_env pin_env_i (.port_oe(port_oe), .ext_level(ext_level), .osc_run(osc_run),
    .osc_o(osc_o), .osc_oe(osc_oe), .port_i(port_i), .osc_i(osc_i));

  // Clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer, held until the ready edge, then one idle cycle
  task automatic apb(input logic wr, input logic [4:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [4:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk("rdata", rd, exp);
  endtask

  // Sink activity over one 4096-cycle PWM period
  task automatic measure();
    hi = 0;
    d01 = 0;
    d08 = 0;
    repeat (4096)
    begin
      @(posedge clk);
      hi += port_sink[0];
      d01 += port_sink[0] ^ port_sink[1];
      d08 += port_sink[0] ^ port_sink[8];
    end
  endtask

  // Poll the configuration until it settles, passing only allowed states
  task automatic wait_cfg(input logic [7:0] fin, input logic [7:0] a, input logic [7:0] b);
    int n;
    n = 0;
    apb(1'b0, 5'h10, 8'h00);
    chk("cfg_start", rd === fin || rd === a || rd === b, 1'b1);
    while (rd !== fin && n < 200)
    begin
      chk("cfg_state", rd === a || rd === b, 1'b1);
      repeat (256) @(posedge clk);
      apb(1'b0, 5'h10, 8'h00);
      n++;
    end
    chk("cfg_final", rd, fin);
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 10; i++)
      rchk(i[4:0], LVL_RST);
    rchk(5'h10, CFG_RST_INT);
    chk("osc_oe", osc_oe, 1'b1);
    chk("sink_rst", port_sink, 10'h000);
    apb(1'b0, 5'h11, 8'h00);
    chk("slverr", err, 1'b1);
    ser_dout <= 1'b1;
    repeat (3) @(posedge clk);
    chk("dout", osc_o, 1'b1);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].wi, rows[i].wd);
      rchk(rows[i].ri, rows[i].ex);
    end
    repeat (4) @(posedge clk);
    rchk(5'h0E, 8'hA5);
    rchk(5'h0F, 8'h02);
    chk("oe_in", port_oe, 10'h000);
    apb(1'b1, 5'h02, 8'h00);
    chk("slverr_ok", err, 1'b0);
    apb(1'b1, 5'h09, 8'h02);
    repeat (4) @(posedge clk);
    chk("oe_low", port_oe, 10'h004);
    rchk(5'h0E, 8'hA1);
    rchk(5'h0F, 8'h00);
    chk("sink_shut", port_sink, 10'h000);
    apb(1'b1, 5'h00, 8'h80);
    apb(1'b1, 5'h01, 8'h80);
    apb(1'b1, 5'h08, 8'h80);
    apb(1'b1, 5'h10, 8'h80);
    osc_run <= 1'b1;
    repeat (4) @(posedge clk);
    chk("osc_oe", osc_oe, 1'b0);
    apb(1'b1, 5'h10, 8'h81);
    rchk(5'h10, 8'h81);
    measure();
    chk("duty", hi > 2024 && hi < 2072, 1'b1);
    chk("inphase", d01 + d08, 0);
    chk("static", port_sink[9], 1'b1);
    chk("port_o", port_o, 10'h000);
    apb(1'b1, 5'h10, 8'h80);
    rchk(5'h10, 8'h90);
    apb(1'b1, 5'h10, 8'h81);
    rchk(5'h10, 8'h81);
    apb(1'b1, 5'h10, 8'h80);
    wait_cfg(8'h88, 8'h90, 8'h90);
    apb(1'b1, 5'h10, 8'h81);
    rchk(5'h10, 8'h81);
    apb(1'b1, 5'h10, 8'h80);
    wait_cfg(8'h80, 8'h90, 8'h88);
    chk("sink_off", port_sink, 10'h000);
    apb(1'b1, 5'h10, 8'hA6);
    rchk(5'h10, 8'hA2);
    apb(1'b1, 5'h10, 8'hA7);
    rchk(5'h10, 8'hA7);
    measure();
    chk("stagger", d01 > 976 && d01 < 1072, 1'b1);
    chk("wrap", d08, 0);
    wait_cfg(8'hA3, 8'hA7, 8'hA7);
    // Mid-run reset returns outputs and registers to defaults
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rst_out", {port_sink, port_oe, port_o, osc_oe, pready}, 32'h0);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk(5'h10, CFG_RST_INT);
    rchk(5'h00, LVL_RST);
    print_verdict();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (90000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule
